/* File: hdl/sibw_consts.svh */
// constants for the smbus index block write target
// Overview of operation
// - start then our address with write bit; device acknowledges a matching address.
// - first byte after address is the starting index; acknowledged, used as first location.
// - second byte is the data byte count; device acknowledges it.
// - count data bytes follow, stored at index through index plus count minus one; indices past the last register are dropped.
// - device acknowledges every data byte, one acknowledge per byte.
// - target address is chosen by the level latched on the address strap pin.
`ifndef SIBW_CONSTS_SVH
`define SIBW_CONSTS_SVH
`define SIBW_ADDR_STRAP0 7'h6B
`define SIBW_ADDR_STRAP_MID 7'h6C
`define SIBW_ADDR_STRAP1 7'h6D
`define SIBW_NUM_REGS 16
`define SIBW_REG_RESET 8'h00
`endif

/* File: hdl/sibw_pkg.sv */
// types for the smbus index block write target
package sibw_pkg;
  typedef enum logic [5:0] {
    SIBW_IDLE = 6'b000001,
    SIBW_ADDR = 6'b000010,
    SIBW_INDEX = 6'b000100,
    SIBW_COUNT = 6'b001000,
    SIBW_DATA = 6'b010000,
    SIBW_IGNORE = 6'b100000
  } sibw_state_t;
endpackage : sibw_pkg

/* File: hdl/sibw_bus_if.sv */
// interface carrying conditioned smbus line events
`timescale 1ns/1ps
interface sibw_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  modport src (output scl_rise, output scl_fall, output sda, output start, output stop);
  modport dst (input scl_rise, input scl_fall, input sda, input start, input stop);
endinterface : sibw_bus_if

/* File: hdl/sibw_line_cond.sv */
// synchroniser and edge finder for scl and sda
`timescale 1ns/1ps
module sibw_line_cond (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  sibw_bus_if.src bus
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [1:0] next_scl_sync;
  logic [1:0] next_sda_sync;
  always_comb begin
    next_scl_sync = {scl_sync[0], i_scl};
    next_sda_sync = {sda_sync[0], i_sda};
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end
  // only the second stage and its delayed copy feed any logic
  assign bus.scl_rise = scl_sync[1] & ~scl_d;
  assign bus.scl_fall = ~scl_sync[1] & scl_d;
  assign bus.sda = sda_sync[1];
  assign bus.start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign bus.stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
endmodule : sibw_line_cond

/* File: hdl/sibw_target.sv */
// smbus index block write target with configuration byte store
`timescale 1ns/1ps
`include "sibw_consts.svh"
module sibw_target #(
  parameter int NUM_REGS = `SIBW_NUM_REGS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_address_strap_pin,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [NUM_REGS*8-1:0] o_regs,
  output logic o_busy
);
  // both lines pass two flops before any edge or condition is decoded
  sibw_bus_if bus ();
  sibw_line_cond u_cond (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .bus(bus)
  );

  // strap pin encoding: 2'b00 low, 2'b01 and 2'b10 mid, 2'b11 high
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic strap_taken;
  logic [6:0] own_addr;
  logic [6:0] next_own_addr;
  logic next_strap_taken;

  sibw_pkg::sibw_state_t state;
  sibw_pkg::sibw_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic ack_phase;
  logic next_ack_phase;
  logic ack_drive;
  logic next_ack_drive;
  logic ack_wait;
  logic next_ack_wait;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [7:0] regs [NUM_REGS];
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rx_byte;

  function automatic logic [6:0] strap_to_addr(input logic [1:0] lvl);
    case (lvl)
      2'b00: strap_to_addr = `SIBW_ADDR_STRAP0;
      2'b11: strap_to_addr = `SIBW_ADDR_STRAP1;
      default: strap_to_addr = `SIBW_ADDR_STRAP_MID;
    endcase
  endfunction : strap_to_addr

  // a frame counts as ours from start until a stop or an address miss
  function automatic logic in_frame(input sibw_pkg::sibw_state_t st);
    in_frame = (st != sibw_pkg::SIBW_IDLE) && (st != sibw_pkg::SIBW_IGNORE);
  endfunction : in_frame

  // strap caught once after reset release, never under reset
  always_comb begin
    next_strap_taken = 1'b1;
    next_own_addr = strap_taken ? own_addr : strap_to_addr(strap_s2);
  end
  always_ff @(posedge i_sys_clk) begin
    strap_s1 <= i_address_strap_pin;
    strap_s2 <= strap_s1;
    if (i_reset) begin
      strap_taken <= 1'b0;
      own_addr <= `SIBW_ADDR_STRAP0;
    end else begin
      strap_taken <= next_strap_taken;
      own_addr <= next_own_addr;
    end
  end

  assign rx_byte = {shreg[6:0], bus.sda};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ack_phase = ack_phase;
    next_ack_drive = ack_drive;
    next_ack_wait = ack_wait;
    next_ptr = ptr;
    next_remain = remain;
    wr_en = 1'b0;
    wr_idx = ptr;
    wr_data = rx_byte;
    if (bus.start) begin
      next_state = sibw_pkg::SIBW_ADDR;
      next_bit_cnt = 3'h0;
      next_ack_phase = 1'b0;
      next_ack_drive = 1'b0;
      next_ack_wait = 1'b0;
    end else if (bus.stop) begin
      next_state = sibw_pkg::SIBW_IDLE;
      next_ack_phase = 1'b0;
      next_ack_drive = 1'b0;
      next_ack_wait = 1'b0;
    end else if (bus.scl_fall && ack_wait) begin
      // sda may only move while scl is low, else the pull would look like a start
      next_ack_wait = 1'b0;
      next_ack_phase = 1'b1;
    end else if (bus.scl_fall && ack_phase) begin
      // ack is released on the falling edge that ends the ninth clock
      next_ack_drive = 1'b0;
      next_ack_phase = 1'b0;
      next_bit_cnt = 3'h0;
    end else if (bus.scl_rise && !ack_phase && !ack_wait && in_frame(state)) begin
      next_shreg = rx_byte;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_ack_wait = 1'b1;
        case (state)
          sibw_pkg::SIBW_ADDR: begin
            // reads are not served by this block, so only the write bit matches
            if (rx_byte[7:1] == own_addr && !rx_byte[0]) begin
              next_ack_drive = 1'b1;
              next_state = sibw_pkg::SIBW_INDEX;
            end else begin
              // a miss stays silent until the next start
              next_state = sibw_pkg::SIBW_IGNORE;
            end
          end
          sibw_pkg::SIBW_INDEX: begin
            next_ptr = rx_byte;
            next_ack_drive = 1'b1;
            next_state = sibw_pkg::SIBW_COUNT;
          end
          sibw_pkg::SIBW_COUNT: begin
            next_remain = rx_byte;
            next_ack_drive = 1'b1;
            next_state = sibw_pkg::SIBW_DATA;
          end
          sibw_pkg::SIBW_DATA: begin
            next_ack_drive = 1'b1;
            // bytes beyond the count are still acked but not stored
            if (remain != 8'h00) begin
              wr_en = (ptr < 8'(NUM_REGS));
              next_ptr = ptr + 8'h01;
              next_remain = remain - 8'h01;
            end
          end
          default: begin
            next_ack_drive = 1'b0;
          end
        endcase
      end
    end
  end

  // ack pulls sda low only once scl has fallen after the eighth bit
  logic next_sda_oe;
  logic next_sda_out;
  logic next_busy;
  always_comb begin
    // taken from the next values so the pull starts and ends with the ninth clock
    next_sda_oe = next_ack_phase & next_ack_drive;
    // open drain: the pin is only ever pulled low, never driven high
    next_sda_out = 1'b0;
    next_busy = in_frame(state);
  end

  // no clock stretching: each scl level must last at least five system clocks
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= sibw_pkg::SIBW_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      ack_wait <= 1'b0;
      ptr <= 8'h00;
      remain <= 8'h00;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ack_phase <= next_ack_phase;
      ack_drive <= next_ack_drive;
      ack_wait <= next_ack_wait;
      ptr <= next_ptr;
      remain <= next_remain;
      o_sda_oe <= next_sda_oe;
      o_sda_out <= next_sda_out;
      o_busy <= next_busy;
    end
  end

  // store written at consecutive indices; out-of-range indices are dropped
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i_reset) begin
        regs[i] <= `SIBW_REG_RESET;
      end else if (wr_en && wr_idx == 8'(i)) begin
        regs[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i_reset) begin
        o_regs[i*8 +: 8] <= `SIBW_REG_RESET;
      end else begin
        o_regs[i*8 +: 8] <= regs[i];
      end
    end
  end
endmodule : sibw_target

/* File: verification/sibw_target_monitor.sv */
// pin-level assertions for the block write target
`timescale 1ns/1ps
module sibw_target_monitor #(
  parameter int NUM_REGS = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_address_strap_pin,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [NUM_REGS*8-1:0] o_regs,
  input wire logic o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_ack_on;
    $rose(o_sda_oe);
  endsequence
  sequence s_stop_seen;
    i_scl && $rose(i_sda);
  endsequence
  a_pull_only: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  a_ack_in_low: assert property (s_ack_on |-> !i_scl)
    else $error("ack began in clock high");
  a_ack_holds: assert property (s_ack_on |-> o_sda_oe [*8])
    else $error("ack dropped early");
  a_ack_ends_low: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("ack released in clock high");
  a_ack_bounded: assert property (s_ack_on |-> ##[9:40] !o_sda_oe)
    else $error("ack held too long");
  a_oe_still_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("ack moved while clock high");
  a_regs_cleared: assert property ($past(i_reset) |-> o_regs == '0)
    else $error("store not cleared");
  a_regs_in_xfer: assert property (!$stable(o_regs) |-> o_busy)
    else $error("store changed outside write");
  a_stop_frees: assert property (s_stop_seen |-> ##[1:8] !o_busy)
    else $error("busy after stop");
endmodule : sibw_target_monitor
bind sibw_target sibw_target_monitor #(.NUM_REGS(NUM_REGS)) u_mon (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .i_address_strap_pin(i_address_strap_pin), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_regs(o_regs), .o_busy(o_busy));

/* File: verification/sibw_host_model.sv */
// smbus host model issuing index block writes
`timescale 1ns/1ps
module sibw_host_model (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  // clock stands high between frames; data changes only in clock low
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start_bit();
    #40 o_sda = 1'b1;
    #40 o_scl = 1'b1;
    #80 o_sda = 1'b0;
    #80 o_scl = 1'b0;
  endtask : start_bit
  // address, index, count and data bytes, msb first, ack read at mid high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40 o_sda = b[i];
      #40 o_scl = 1'b1;
      #80 o_scl = 1'b0;
    end
    #40 o_sda = 1'b1;
    #40 o_scl = 1'b1;
    #40 ack = ~i_sda;
    #40 o_scl = 1'b0;
  endtask : send_byte
  task automatic stop_bit();
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #80 o_sda = 1'b1;
    #80;
  endtask : stop_bit
endmodule : sibw_host_model

/* File: verification/testbench.sv */
// self-checking bench for the block write target
`timescale 1ns/1ps
`include "sibw_consts.svh"
module testbench;
  localparam int NR = 16;
  typedef struct {logic [1:0] s; logic [7:0] ab, ix, n; logic [31:0] d; logic a;} sibw_row_t;
  logic clk, rst, scl, sda_h, sda, out, oe, busy, ack, hit;
  logic [1:0] strap;
  logic [7:0] b;
  logic [NR*8-1:0] regs, exp_r;
  int n_mismatch, n_checks;
  // strap, address byte, index, count, data bytes from the top, expected ack
  sibw_row_t rows [6] = '{
    '{2'b00, 8'hDA, 8'h02, 8'h01, 32'h77000000, 1'b0},
    '{2'b11, 8'hDB, 8'h03, 8'h01, 32'h66000000, 1'b0},
    '{2'b01, 8'hD8, 8'h03, 8'h00, 32'h0, 1'b1},
    '{2'b00, 8'hD6, 8'h00, 8'h04, 32'h11223344, 1'b1},
    '{2'b11, 8'hDA, 8'h0E, 8'h02, 32'hA55A0000, 1'b1},
    '{2'b10, 8'hD8, 8'h0F, 8'h03, 32'hC3F00F00, 1'b1}};
  // released line is pulled up
  assign sda = sda_h & ~(oe & ~out);
  sibw_target #(.NUM_REGS(NR)) DUT (.i_sys_clk(clk), .i_reset(rst), .i_scl(scl),
    .i_sda(sda), .i_address_strap_pin(strap), .o_sda_out(out), .o_sda_oe(oe),
    .o_regs(regs), .o_busy(busy));
  sibw_host_model host (.o_scl(scl), .o_sda(sda_h), .i_sda(sda));
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // strap must stand before release since it is captured just after
  task automatic do_reset(input logic [1:0] s);
    @(negedge clk);
    strap = s;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
  endtask : do_reset
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    strap = 2'b00;
    n_mismatch = 0;
    n_checks = 0;
    foreach (rows[r]) begin
      do_reset(rows[r].s);
      chk(regs === '0 && busy === 1'b0 && oe === 1'b0 && out === 1'b0, "reset state");
      hit = rows[r].a;
      exp_r = '0;
      host.start_bit();
      host.send_byte(rows[r].ab, ack);
      chk(ack === hit, "address ack");
      host.send_byte(rows[r].ix, ack);
      chk(ack === hit, "index ack");
      host.send_byte(rows[r].n, ack);
      chk(ack === hit, "count ack");
      for (int k = 0; k < rows[r].n; k++) begin
        b = rows[r].d[31-8*k -: 8];
        host.send_byte(b, ack);
        chk(ack === hit, "data ack");
        if (hit && rows[r].ix + k < NR) exp_r[(rows[r].ix+k)*8 +: 8] = b;
      end
      host.stop_bit();
      @(negedge clk);
      chk(regs === exp_r && busy === 1'b0, "stored bytes");
    end
    // repeated start restarts at the address; a byte past the count is acked, not kept
    host.start_bit();
    host.send_byte(8'hD8, ack);
    host.send_byte(8'h05, ack);
    host.start_bit();
    host.send_byte(8'hD8, ack);
    chk(ack === 1'b1, "restart address ack");
    host.send_byte(8'h01, ack);
    host.send_byte(8'h01, ack);
    host.send_byte(8'h9C, ack);
    chk(ack === 1'b1 && busy === 1'b1, "restart data ack");
    host.send_byte(8'h77, ack);
    chk(ack === 1'b1, "surplus byte ack");
    host.stop_bit();
    @(negedge clk);
    exp_r[8 +: 8] = 8'h9C;
    chk(regs === exp_r && busy === 1'b0, "restart store");
    // reset in mid-frame must drop the transfer and the store
    host.start_bit();
    host.send_byte(8'hD8, ack);
    host.send_byte(8'h01, ack);
    chk(busy === 1'b1, "busy in frame");
    do_reset(2'b00);
    chk(regs === '0 && busy === 1'b0 && oe === 1'b0, "mid-frame reset");
    host.stop_bit();
    give_verdict();
  end
endmodule : testbench
